// >>> design/spms_top.sv
// Serial port: multiprocessor-format async transmit, clocked sync mode.
// Assumes an Avalon-MM master on CLK_IN; serial pins are asynchronous.
`timescale 1ns/1ps
module spms_top
	import spms_pkg::*;
#(
	parameter int BAUD_W = 16
) (
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESET_N_IN,
	// Avalon-MM slave
	input  wire logic [4:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	// Serial lines
	output logic             TXD_OUT,
	input  wire logic        RXD_IN,
	input  wire logic        SCK_IN,
	output logic             SCK_OUT,
	output logic             SCK_OE_OUT,
	// Interrupt requests
	output logic             TX_EMPTY_IRQ_OUT,
	output logic             TX_COMPLETE_IRQ_OUT,
	output logic             RX_FULL_IRQ_OUT,
	output logic             RX_ERROR_IRQ_OUT
);

	// Elaboration check on divider width
	generate
		if (BAUD_W < 2 || BAUD_W > 16) begin : g_bad_width
			$error("BAUD_W must be 2 to 16");
		end
	endgenerate

	// Registers
	logic [7:0]        mode_reg;
	logic [7:0]        ctrl_reg;
	logic [7:0]        tx_holding_reg;
	logic [7:0]        rx_data_reg;
	logic [BAUD_W-1:0] baud_reg;
	logic [BAUD_W-1:0] baud_cnt_reg;
	logic              phase_reg;
	logic              ack_reg;
	logic [31:0]       rdata_reg;
	logic              tx_empty_reg;
	logic              tx_done_reg;
	logic              rx_full_reg;
	logic              overrun_reg;
	logic              parity_err_reg;
	logic              framing_err_reg;
	logic              mp_bit_reg;
	logic              rxd_s1_reg;
	logic              rxd_s2_reg;
	logic              sck_s1_reg;
	logic              sck_s2_reg;
	logic              sck_s3_reg;
	logic              sck_int_reg;
	spms_tx_state_t    tx_state_reg;
	logic [2:0]        tx_cnt_reg;
	logic [7:0]        tx_shift_reg;
	logic              txd_reg;
	logic              stop_cnt_reg;
	logic              chain_reg;
	logic [2:0]        rx_cnt_reg;
	logic [7:0]        rx_shift_reg;

	// Next values from the transmitter process
	spms_tx_state_t    tx_state_next;
	logic [2:0]        tx_cnt_next;
	logic [7:0]        tx_shift_next;
	logic              txd_next;
	logic              stop_cnt_next;
	logic              chain_next;
	logic              load_ev;
	logic              tx_complete_flag_set;
	logic              enter_stop;

	// Bus decode
	spms_avs_req_t req;
	logic          req_any;
	logic          wr;
	logic [7:0]    wdat;
	logic          wr_mode;
	logic          wr_ctrl;
	logic          wr_stat;
	logic          wr_txh;
	logic          wr_baud;
	logic [7:0]    stat_vec;
	logic [31:0]   rd_mux;

	assign req      = '{AVS_READ_IN, AVS_WRITE_IN, AVS_ADDRESS_IN, AVS_WRITEDATA_IN};
	assign req_any  = req.read | req.write;
	assign wr       = req.write & ack_reg;
	assign wdat     = req.writedata[7:0];
	assign wr_mode  = wr & (req.address == OFS_MODE);
	assign wr_ctrl  = wr & (req.address == OFS_CTRL);
	assign wr_stat  = wr & (req.address == OFS_STAT);
	assign wr_txh   = wr & (req.address == OFS_TXH);
	assign wr_baud  = wr & (req.address == OFS_BAUD);

	// One wait state on every access; answer on the second cycle
	assign AVS_WAITREQUEST_OUT = req_any & ~ack_reg;
	assign AVS_READDATA_OUT    = rdata_reg;

	// Status image
	assign stat_vec[TX_BUFFER_EMPTY_FLAG] = tx_empty_reg;
	assign stat_vec[RX_FULL_FLAG]         = rx_full_reg;
	assign stat_vec[OVERRUN_FLAG]         = overrun_reg;
	assign stat_vec[FRAMING_ERROR_FLAG]   = framing_err_reg;
	assign stat_vec[PARITY_ERROR_FLAG]    = parity_err_reg;
	assign stat_vec[TX_COMPLETE_FLAG]     = tx_done_reg;
	assign stat_vec[1]                    = 1'b0;
	assign stat_vec[MP_BIT_TO_SEND]       = mp_bit_reg;

	// Read selection; unmapped offsets read zero
	assign rd_mux =
		(req.address == OFS_MODE) ? {24'h000000, mode_reg} :
		(req.address == OFS_CTRL) ? {24'h000000, ctrl_reg} :
		(req.address == OFS_STAT) ? {24'h000000, stat_vec} :
		(req.address == OFS_TXH)  ? {24'h000000, tx_holding_reg} :
		(req.address == OFS_RXD)  ? {24'h000000, rx_data_reg} :
		(req.address == OFS_BAUD) ? {{(32-BAUD_W){1'b0}}, baud_reg} :
		32'h00000000;

	// Mode and enable decode
	logic sync_mode;
	logic int_clk;
	logic te;
	logic re;
	logic err_any;

	assign sync_mode = mode_reg[MODE_SYNC];
	assign int_clk   = ~ctrl_reg[CLOCK_SOURCE_SELECT_HI];
	assign te        = ctrl_reg[TRANSMITTER_ENABLE];
	assign re        = ctrl_reg[RECEIVER_ENABLE];
	assign err_any   = overrun_reg | parity_err_reg | framing_err_reg;

	// Clock pin drives only for the internal sync clock
	assign SCK_OUT    = sck_int_reg;
	assign SCK_OE_OUT = sync_mode & int_clk;

	// Baud divider: half-bit enable, bit enable every second one
	logic half_tick;
	logic bit_step;
	logic baud_clr;

	assign half_tick = (baud_cnt_reg == baud_reg);
	assign bit_step  = half_tick & phase_reg;

	// Internal serial clock and edge events
	logic run_clk;
	logic int_fall;
	logic int_rise;
	logic fall_ev;
	logic rise_ev;

	// Receive-only keeps pulsing; errors stop it
	assign run_clk  = sync_mode & int_clk & ~err_any
		& ((tx_state_reg == TX_SYNC) | (re & ~te));
	assign int_fall = half_tick & sck_int_reg & run_clk;
	assign int_rise = half_tick & ~sck_int_reg;
	assign fall_ev  = sync_mode & (int_clk ? int_fall : (sck_s3_reg & ~sck_s2_reg));
	assign rise_ev  = sync_mode & (int_clk ? int_rise : (~sck_s3_reg & sck_s2_reg));

	// Transmit start and chaining conditions
	logic tx_start;
	logic can_chain;
	logic [2:0] last_bit;

	assign can_chain = te & ~tx_empty_reg & ~(sync_mode & err_any);
	assign tx_start  = can_chain & (tx_state_reg == TX_IDLE);
	assign baud_clr  = tx_start & ~sync_mode;
	assign last_bit  = mode_reg[MODE_CHR7] ? LAST_BIT7 : LAST_BIT8;

	// Transmitter next-state logic
	always_comb begin
		tx_state_next = tx_state_reg;
		tx_cnt_next   = tx_cnt_reg;
		tx_shift_next = tx_shift_reg;
		txd_next      = txd_reg;
		stop_cnt_next = stop_cnt_reg;
		chain_next    = chain_reg;
		load_ev       = 1'b0;
		tx_complete_flag_set      = 1'b0;
		enter_stop    = 1'b0;
		case (tx_state_reg)
			TX_IDLE: begin
				if (tx_start) begin
					load_ev       = 1'b1;
					tx_shift_next = tx_holding_reg;
					tx_cnt_next   = 3'h0;
					if (sync_mode) begin
						tx_state_next = TX_SYNC;
					end else begin
						tx_state_next = TX_START;
						txd_next      = 1'b0;
					end
				end
			end
			TX_START: begin
				if (bit_step) begin
					tx_state_next = TX_DATA;
					txd_next      = tx_shift_reg[0];
				end
			end
			TX_DATA: begin
				if (bit_step) begin
					if (tx_cnt_reg == last_bit) begin
						if (mode_reg[MODE_MP]) begin
							tx_state_next = TX_MPB;
							txd_next      = mp_bit_reg;
						end else begin
							enter_stop = 1'b1;
						end
					end else begin
						tx_cnt_next = 3'(tx_cnt_reg + 3'h1);
						txd_next    = tx_shift_reg[3'(tx_cnt_reg + 3'h1)];
					end
				end
			end
			TX_MPB: begin
				if (bit_step) begin
					enter_stop = 1'b1;
				end
			end
			TX_STOP: begin
				if (bit_step) begin
					if (mode_reg[MODE_STOP2] && !stop_cnt_reg) begin
						stop_cnt_next = 1'b1;
					end else if (chain_reg) begin
						tx_state_next = TX_START;
						tx_cnt_next   = 3'h0;
						txd_next      = 1'b0;
					end else begin
						tx_state_next = TX_IDLE;
					end
				end
			end
			TX_SYNC: begin
				if (fall_ev) begin
					txd_next = tx_shift_reg[tx_cnt_reg];
				end
				if (rise_ev) begin
					if (tx_cnt_reg == LAST_BIT8) begin
						if (can_chain) begin
							load_ev       = 1'b1;
							tx_shift_next = tx_holding_reg;
							tx_cnt_next   = 3'h0;
						end else begin
							tx_complete_flag_set      = 1'b1;
							tx_state_next = TX_IDLE;
						end
					end else begin
						tx_cnt_next = 3'(tx_cnt_reg + 3'h1);
					end
				end
			end
			default: begin
				tx_state_next = TX_IDLE;
			end
		endcase
		// Stop entry samples the empty flag once per frame
		if (enter_stop) begin
			tx_state_next = TX_STOP;
			txd_next      = 1'b1;
			stop_cnt_next = 1'b0;
			chain_next    = can_chain;
			if (can_chain) begin
				load_ev       = 1'b1;
				tx_shift_next = tx_holding_reg;
			end else begin
				tx_complete_flag_set = 1'b1;
			end
		end
		// Disabled transmitter is held in reset
		if (!te) begin
			tx_state_next = TX_IDLE;
			tx_shift_next = 8'h00;
			tx_cnt_next   = 3'h0;
			txd_next      = 1'b1;
			chain_next    = 1'b0;
			load_ev       = 1'b0;
			tx_complete_flag_set      = 1'b0;
		end
	end

	// Receiver events
	logic       rx_shift_en;
	logic       rx_done;
	logic [7:0] rx_byte;

	assign rx_shift_en = rise_ev & re & ~err_any;
	assign rx_done     = rx_shift_en & (rx_cnt_reg == LAST_BIT8);
	assign rx_byte     = {rxd_s2_reg, rx_shift_reg[7:1]};

	// Flag next values; hardware set wins over a software clear
	logic tx_empty_next;
	logic tx_done_next;
	logic rx_full_next;
	logic overrun_next;

	assign tx_empty_next = (tx_empty_reg & ~(wr_stat & ~wdat[TX_BUFFER_EMPTY_FLAG]))
		| load_ev | ~te;
	assign tx_done_next  = (tx_done_reg & ~(wr_stat & ~wdat[TX_COMPLETE_FLAG])
		& ~(wr_stat & ~wdat[TX_BUFFER_EMPTY_FLAG])) | tx_complete_flag_set;
	assign rx_full_next  = (rx_full_reg & ~(wr_stat & ~wdat[RX_FULL_FLAG]))
		| (rx_done & ~rx_full_reg);
	assign overrun_next  = (overrun_reg & ~(wr_stat & ~wdat[OVERRUN_FLAG]))
		| (rx_done & rx_full_reg);

	// Interrupt requests are levels from flags and enables
	assign TX_EMPTY_IRQ_OUT    = tx_empty_reg & ctrl_reg[TX_EMPTY_IRQ_ENABLE];
	assign TX_COMPLETE_IRQ_OUT = tx_done_reg & ctrl_reg[TX_COMPLETE_IRQ_ENABLE];
	assign RX_FULL_IRQ_OUT     = rx_full_reg & ctrl_reg[RX_IRQ_ENABLE];
	assign RX_ERROR_IRQ_OUT    = err_any & ctrl_reg[RX_IRQ_ENABLE];
	assign TXD_OUT             = txd_reg;

	// Bus handshake and read data
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg <= req_any & ~ack_reg;
			if (req.read && !ack_reg) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			mode_reg       <= MODE_RST;
			ctrl_reg       <= CTRL_RST;
			tx_holding_reg <= 8'h00;
			baud_reg       <= BAUD_W'(BAUD_RST);
			mp_bit_reg     <= STAT_RST[MP_BIT_TO_SEND];
		end else begin
			if (wr_mode) mode_reg <= wdat;
			if (wr_ctrl) ctrl_reg <= wdat;
			if (wr_txh) tx_holding_reg <= wdat;
			if (wr_baud) baud_reg <= req.writedata[BAUD_W-1:0];
			if (wr_stat) mp_bit_reg <= wdat[MP_BIT_TO_SEND];
		end
	end

	// Status flags; receiver disable leaves them alone
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			tx_empty_reg    <= STAT_RST[TX_BUFFER_EMPTY_FLAG];
			tx_done_reg     <= STAT_RST[TX_COMPLETE_FLAG];
			rx_full_reg     <= STAT_RST[RX_FULL_FLAG];
			overrun_reg     <= STAT_RST[OVERRUN_FLAG];
			parity_err_reg  <= STAT_RST[PARITY_ERROR_FLAG];
			framing_err_reg <= STAT_RST[FRAMING_ERROR_FLAG];
		end else begin
			tx_empty_reg    <= tx_empty_next;
			tx_done_reg     <= tx_done_next;
			rx_full_reg     <= rx_full_next;
			overrun_reg     <= overrun_next;
			parity_err_reg  <= parity_err_reg & ~(wr_stat & ~wdat[PARITY_ERROR_FLAG]);
			framing_err_reg <= framing_err_reg & ~(wr_stat & ~wdat[FRAMING_ERROR_FLAG]);
		end
	end

	// Pin synchronisers and internal clock
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rxd_s1_reg  <= 1'b1;
			rxd_s2_reg  <= 1'b1;
			sck_s1_reg  <= 1'b1;
			sck_s2_reg  <= 1'b1;
			sck_s3_reg  <= 1'b1;
			sck_int_reg <= 1'b1;
		end else begin
			rxd_s1_reg  <= RXD_IN;
			rxd_s2_reg  <= rxd_s1_reg;
			sck_s1_reg  <= SCK_IN;
			sck_s2_reg  <= sck_s1_reg;
			sck_s3_reg  <= sck_s2_reg;
			if (int_fall || int_rise) sck_int_reg <= ~sck_int_reg;
		end
	end

	// Baud divider; an async frame started from idle restarts it for a full start bit
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			baud_cnt_reg <= '0;
			phase_reg    <= 1'b0;
		end else if (half_tick || baud_clr) begin
			baud_cnt_reg <= '0;
			phase_reg    <= ~phase_reg & ~baud_clr;
		end else begin
			baud_cnt_reg <= BAUD_W'(baud_cnt_reg + 1'b1);
		end
	end

	// Transmitter registers
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			tx_state_reg <= TX_IDLE;
			tx_cnt_reg   <= 3'h0;
			tx_shift_reg <= 8'h00;
			txd_reg      <= 1'b1;
			stop_cnt_reg <= 1'b0;
			chain_reg    <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_cnt_reg   <= tx_cnt_next;
			tx_shift_reg <= tx_shift_next;
			txd_reg      <= txd_next;
			stop_cnt_reg <= stop_cnt_next;
			chain_reg    <= chain_next;
		end
	end

	// Receiver; a full holding register drops the new byte
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rx_cnt_reg   <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_data_reg  <= 8'h00;
		end else begin
			if (!re || !sync_mode) rx_cnt_reg <= 3'h0;
			else if (rx_shift_en) rx_cnt_reg <= 3'(rx_cnt_reg + 3'h1);
			if (rx_shift_en) rx_shift_reg <= rx_byte;
			if (rx_done && !rx_full_reg) rx_data_reg <= rx_byte;
		end
	end

	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	sequence s_sync_last_idle;
		rise_ev && tx_state_reg == TX_SYNC && tx_cnt_reg == LAST_BIT8 && !can_chain && te;
	endsequence

	sequence s_stop_no_chain;
		enter_stop && !can_chain && te;
	endsequence

	a_load_sets_empty: assert property (
		tx_start |=> tx_empty_reg && tx_state_reg != TX_IDLE)
		else $error("load did not set empty flag");
	a_start_bit_low: assert property (tx_state_reg == TX_START |-> !txd_reg)
		else $error("start bit not low");
	a_mp_bit_value: assert property (
		$rose(tx_state_reg == TX_MPB) |-> txd_reg == $past(mp_bit_reg))
		else $error("multiprocessor bit wrong");
	a_stop_bit_high: assert property (tx_state_reg == TX_STOP |-> txd_reg)
		else $error("stop bit not high");
	a_async_idle_high: assert property (
		!sync_mode && $past(!sync_mode) && tx_state_reg == TX_IDLE |-> txd_reg)
		else $error("async line not idle high");
	a_stop_complete: assert property (
		s_stop_no_chain |=> tx_done_reg && tx_state_reg == TX_STOP)
		else $error("completion flag not set at stop");
	a_sync_data_hold: assert property (
		te && tx_state_reg == TX_SYNC && !fall_ev |=> $stable(txd_reg))
		else $error("sync data moved off falling edge");
	a_sync_last_bit: assert property (
		s_sync_last_idle |=> tx_done_reg && tx_state_reg == TX_IDLE ##1 $stable(txd_reg))
		else $error("sync end not handled");
	a_te_off_reset: assert property (
		!te |=> tx_empty_reg && tx_state_reg == TX_IDLE && tx_shift_reg == 8'h00)
		else $error("transmitter disable ignored");
	a_rx_store: assert property (
		rx_done && !rx_full_reg |=> rx_full_reg && rx_data_reg == $past(rx_byte))
		else $error("received byte not stored");
	a_rx_overrun: assert property (
		rx_done && rx_full_reg |=> overrun_reg && $stable(rx_data_reg))
		else $error("overrun not flagged");
	// Overrun in sync mode blocks reception too, so it guards the full flag
	a_err_no_full: assert property (
		parity_err_reg || framing_err_reg || (sync_mode && overrun_reg) |=> !$rose(rx_full_reg))
		else $error("full flag set during error");

endmodule // spms_top

// >>> pkg/spms_pkg.sv
// Package for the serial port block: register map, field positions,
// reset values, bus request carrier and transmitter states.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package spms_pkg;

	// Register byte offsets
	localparam logic [4:0] OFS_MODE = 5'h00; // serial_mode_register
	localparam logic [4:0] OFS_CTRL = 5'h04; // serial_control_register
	localparam logic [4:0] OFS_STAT = 5'h08; // serial_status_register
	localparam logic [4:0] OFS_TXH  = 5'h0C; // tx_holding_register
	localparam logic [4:0] OFS_RXD  = 5'h10; // rx_data_register
	localparam logic [4:0] OFS_BAUD = 5'h14; // baud divider

	// Mode register fields
	localparam int MODE_SYNC  = 0;
	localparam int MODE_CHR7  = 1;
	localparam int MODE_STOP2 = 2;
	localparam int MODE_MP    = 3;

	// Control register fields
	localparam int CLOCK_SOURCE_SELECT_LO = 0;
	localparam int CLOCK_SOURCE_SELECT_HI = 1;
	localparam int TX_COMPLETE_IRQ_ENABLE = 2;
	localparam int RECEIVER_ENABLE        = 4;
	localparam int TRANSMITTER_ENABLE     = 5;
	localparam int RX_IRQ_ENABLE          = 6;
	localparam int TX_EMPTY_IRQ_ENABLE    = 7;

	// Status register fields
	localparam int MP_BIT_TO_SEND       = 0;
	localparam int TX_COMPLETE_FLAG     = 2;
	localparam int PARITY_ERROR_FLAG    = 3;
	localparam int FRAMING_ERROR_FLAG   = 4;
	localparam int OVERRUN_FLAG         = 5;
	localparam int RX_FULL_FLAG         = 6;
	localparam int TX_BUFFER_EMPTY_FLAG = 7;

	// Reset values
	localparam logic [7:0]  MODE_RST = 8'h00;
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [7:0]  STAT_RST = 8'h84;
	localparam logic [15:0] BAUD_RST = 16'h0003;

	// Last bit index of a character
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;

	// Bus request carrier
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
	} spms_avs_req_t;

	// Transmitter states
	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_MPB,
		TX_STOP,
		TX_SYNC
	} spms_tx_state_t;

endpackage

// >>> verif/spms_remote_station.sv
// Remote station: drives an external serial clock and receive data.
// Assumes the bench pulses go_in and waits out the 8-bit frame.
`timescale 1ns/1ps
module spms_remote_station (
	// Bench control
	input  wire logic       go_in,
	input  wire logic [7:0] byte_in,
	// Serial lines
	input  wire logic       txd_in,
	output logic            sck_out,
	output logic            rxd_out,
	output logic [7:0]      byte_out
);
	// Clock stands high between frames; data line flips once released
	initial begin
		sck_out = 1'b1;
		rxd_out = 1'b1;
		byte_out = 8'h00;
		forever begin
			@(posedge go_in);
			#7;
			for (int i = 0; i < 8; i++) begin
				sck_out = 1'b0;
				rxd_out = byte_in[i];
				#100;
				sck_out = 1'b1;
				byte_out[i] = txd_in;
				#100;
			end
			rxd_out = ~rxd_out;
		end
	end
endmodule // spms_remote_station

// >>> verif/spms_top_bench.sv
// Bench for the serial port: Avalon-MM register tasks, async frame sampling,
// sync transfers against the remote station. Assumes baud reset value 3.
`timescale 1ns/1ps
module spms_top_bench
	import spms_pkg::*;
;
	logic          clk, rst_n, txd, sck, rxd, sck_o, sck_oe, wreq, go;
	logic [3:0]    irq;
	logic [7:0]    sbyte, rbyte;
	logic [31:0]   rdata, rd;
	spms_avs_req_t req;
	int            fail_count, checks, cycles;

	spms_top dut_u (
		.CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(req.address),
		.AVS_READ_IN(req.read), .AVS_WRITE_IN(req.write), .AVS_WRITEDATA_IN(req.writedata),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .TXD_OUT(txd),
		.RXD_IN(rxd), .SCK_IN(sck), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe),
		.TX_EMPTY_IRQ_OUT(irq[0]), .TX_COMPLETE_IRQ_OUT(irq[1]),
		.RX_FULL_IRQ_OUT(irq[2]), .RX_ERROR_IRQ_OUT(irq[3])
	);

	spms_remote_station far_u (
		.go_in(go), .byte_in(sbyte), .txd_in(txd),
		.sck_out(sck), .rxd_out(rxd), .byte_out(rbyte)
	);

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard, far above the fifteen hundred or so cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{read: !wr, write: wr, address: a, writedata: d};
		do @(posedge clk); while (wreq !== 1'b0);
		rd = rdata;
		req <= '0;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(what, e, rd);
	endtask

	// Samples n bits at mid-bit, 8 clocks per bit
	task automatic get_bits(input int n, output logic [31:0] b);
		b = '0;
		for (int k = 0; k < 400 && txd !== 1'b0; k++) @(posedge clk);
		repeat (4) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			b[i] = txd;
			repeat (8) @(posedge clk);
		end
	endtask

	// Counts falling edges of the internal serial clock over n cycles
	task automatic falls(input int n, output int f);
		logic p;
		p = sck_o;
		f = 0;
		repeat (n) begin
			@(posedge clk);
			if (p === 1'b1 && sck_o === 1'b0)
				f++;
			p = sck_o;
		end
	endtask

	// Two async frames, the second loaded while the first runs
	task automatic send2(input logic [7:0] md, input logic [7:0] d1, input logic [7:0] d2,
		input logic [7:0] st, input int n, output logic [31:0] b);
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_MODE, {24'h0, md});
		bus(1'b1, OFS_CTRL, 32'hA4);
		bus(1'b1, OFS_TXH, {24'h0, d1});
		bus(1'b1, OFS_STAT, {24'h0, st});
		fork
			get_bits(n, b);
			begin
				repeat (3) @(posedge clk);
				chk("empty irq", 32'h1, {31'h0, irq[0]});
				bus(1'b1, OFS_TXH, {24'h0, d2});
				bus(1'b1, OFS_STAT, {24'h0, st});
			end
		join
	endtask

	// Station sends one byte and clocks ours back
	task automatic link(input logic [7:0] v);
		@(posedge clk);
		sbyte <= v;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (80) @(posedge clk);
	endtask

	// Main sequence
	initial begin
		logic [31:0] b;
		int f;
		rst_n = 1'b0;
		req = '0;
		go = 1'b0;
		sbyte = 8'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk("idle pins", 32'h3, {26'h0, irq, txd, sck_o});
		rdchk("status", OFS_STAT, 32'h84);
		rdchk("unmapped", 5'h18, 32'h0);
		// Multiprocessor frames, chained
		send2(8'h08, 8'hA5, 8'h3C, 8'h01, 22, b);
		chk("frames", {10'h0, 2'b11, 8'h3C, 1'b0, 2'b11, 8'hA5, 1'b0}, b);
		repeat (20) @(posedge clk);
		chk("mark", 32'h1, {31'h0, txd});
		chk("complete irq", 32'h1, {31'h0, irq[1]});
		rdchk("status", OFS_STAT, 32'h85);
		// Plain 8-bit frames, no multiprocessor bit
		send2(8'h00, 8'hC3, 8'h81, 8'h00, 20, b);
		chk("frames8", {12'h0, 1'b1, 8'h81, 1'b0, 1'b1, 8'hC3, 1'b0}, b);
		// 7-bit, two stops, then disable mid-frame
		send2(8'h0E, 8'h55, 8'h66, 8'h00, 12, b);
		chk("frame7", {20'h0, 1'b0, 2'b11, 1'b0, 7'h55, 1'b0}, b);
		bus(1'b1, OFS_TXH, 32'h77);
		bus(1'b1, OFS_STAT, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b0, OFS_STAT, 32'h0);
		chk("empty", 32'h80, rd & 32'h80);
		falls(0, f);
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			f += (txd !== 1'b1);
		end
		chk("line low", 32'h0, f);
		// Sync, external clock
		bus(1'b1, OFS_STAT, 32'h0);
		rdchk("no errors", OFS_STAT, 32'h80);
		bus(1'b1, OFS_MODE, 32'h01);
		bus(1'b1, OFS_CTRL, 32'h72);
		// Control lands at this edge; look one edge later
		@(posedge clk);
		chk("oe ext", 32'h0, {31'h0, sck_oe});
		bus(1'b1, OFS_TXH, 32'h43);
		bus(1'b1, OFS_STAT, 32'h0);
		link(8'h96);
		chk("far byte", 32'h43, {24'h0, rbyte});
		chk("msb held", 32'h0, {31'h0, txd});
		chk("rx irq", 32'h1, {31'h0, irq[2]});
		rdchk("rx data", OFS_RXD, 32'h96);
		rdchk("status", OFS_STAT, 32'hC4);
		link(8'h5A);
		rdchk("rx kept", OFS_RXD, 32'h96);
		rdchk("status", OFS_STAT, 32'hE4);
		chk("err irq", 32'h1, {31'h0, irq[3]});
		bus(1'b1, OFS_TXH, 32'h11);
		bus(1'b1, OFS_STAT, 32'h60);
		link(8'hFF);
		chk("blocked tx", 32'h0, {24'h0, rbyte});
		rdchk("status", OFS_STAT, 32'h60);
		bus(1'b1, OFS_CTRL, 32'h22);
		rdchk("status", OFS_STAT, 32'h60);
		rdchk("rx data", OFS_RXD, 32'h96);
		bus(1'b1, OFS_CTRL, 32'h02);
		rdchk("status", OFS_STAT, 32'hE0);
		// Sync, internal clock
		bus(1'b1, OFS_STAT, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h20);
		@(posedge clk);
		chk("oe int", 32'h1, {31'h0, sck_oe});
		bus(1'b1, OFS_TXH, 32'h0F);
		bus(1'b1, OFS_STAT, 32'h0);
		falls(150, f);
		chk("pulses", 32'h8, f);
		chk("sck idle", 32'h1, {31'h0, sck_o});
		bus(1'b1, OFS_CTRL, 32'h10);
		falls(300, f);
		chk("rx pulses", 32'h10, f);
		rdchk("status", OFS_STAT, 32'hE4);
		close_out();
	end
endmodule // spms_top_bench
